// file: ebm_top.sv
// block memory with ram write behaviours and a flagged fifo mode
`timescale 1ns/1ps
`default_nettype none
`include "ebm_map.svh"
module ebm_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fifo_mode,
  input wire logic [`EBM_MODE_W-1:0] write_mode,
  input wire logic ram_clk_enable,
  input wire logic ram_select,
  input wire logic ram_write_enable,
  input wire logic output_clk_enable,
  input wire logic [`EBM_ADDR_W-1:0] ram_addr,
  input wire logic [`EBM_DATA_W-1:0] data_in_bus,
  output logic [`EBM_DATA_W-1:0] ram_data_out,
  input wire logic write_clock_enable,
  input wire logic write_enable,
  input wire logic write_port_select,
  input wire logic full_cascade_in,
  input wire logic read_clock_enable,
  input wire logic read_enable_in,
  input wire logic read_port_select,
  input wire logic empty_cascade_in,
  input wire logic read_pointer_reset,
  input wire logic [`EBM_ADDR_W-1:0] full_threshold,
  input wire logic [`EBM_ADDR_W-1:0] almost_full_threshold,
  input wire logic [`EBM_ADDR_W-1:0] almost_empty_threshold,
  output logic [`EBM_DATA_W-1:0] fifo_data_out,
  output logic fifo_write_ready,
  output logic full_flag,
  output logic almost_full_flag,
  output logic empty_flag,
  output logic almost_empty_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // threshold clamp, used for all programmable levels
  function automatic logic [`EBM_ADDR_W-1:0] ebm_clamp(
    input logic [`EBM_ADDR_W-1:0] value,
    input logic [`EBM_ADDR_W-1:0] lo,
    input logic [`EBM_ADDR_W-1:0] hi
  );
    logic [`EBM_ADDR_W-1:0] res;
    res = value;
    if (res > hi) begin
      res = hi;
    end
    if (res < lo) begin
      res = lo;
    end
    return res;
  endfunction : ebm_clamp

  ////////////////////////////////////////////////////////////////////////////
  // ram port
  logic [`EBM_DATA_W-1:0] mem_reg [`EBM_DEPTH];
  logic [`EBM_DATA_W-1:0] ram_data_out_reg;
  logic [`EBM_DATA_W-1:0] ram_data_out_next;
  logic [`EBM_DATA_W-1:0] ram_rd_word;
  ebm_pkg::ebm_wmode_type wmode;
  logic ram_access;
  logic ram_write;
  logic ram_read;
  logic ram_out_load;

  assign wmode = ebm_pkg::ebm_wmode_type'(write_mode);
  assign ram_access = !fifo_mode && ram_clk_enable && ram_select;
  assign ram_write = ram_access && ram_write_enable;
  assign ram_read = ram_access && !ram_write_enable;
  assign ram_rd_word = mem_reg[ram_addr];
  assign ram_out_load = ram_access && output_clk_enable;

  always_comb begin
    ram_data_out_next = ram_data_out_reg;
    if (ram_read) begin
      ram_data_out_next = ram_rd_word;
    end else if (ram_write) begin
      case (wmode)
        ebm_pkg::EBM_WRITE_THRU: ram_data_out_next = data_in_bus;
        ebm_pkg::EBM_READ_BEFORE: ram_data_out_next = ram_rd_word;
        default: ram_data_out_next = ram_data_out_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ram_data_out_reg <= '0;
    end else if (ram_out_load) begin
      ram_data_out_reg <= ram_data_out_next;
    end
  end

  // old word is read before this edge overwrites it
  always_ff @(posedge core_clk) begin
    if (ram_write) begin
      mem_reg[ram_addr] <= data_in_bus;
    end
  end

  assign ram_data_out = ram_data_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // fifo port qualification
  logic wr_req;
  logic rd_req;
  logic wr_accept;
  logic rd_accept;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [`EBM_DATA_W-1:0] buf_out_data;
  logic [`EBM_LEVEL_W-1:0] fifo_level;
  logic rd_restart;
  // flag registers come first, the request gating reads them
  logic full_flag_reg;
  logic almost_full_flag_reg;
  logic empty_flag_reg;
  logic almost_empty_flag_reg;

  // write qualified by clock enable and write enable
  // cascade input is the second write select
  // write chip select qualifies the write port
  assign wr_req = fifo_mode && write_clock_enable && write_enable
                  && write_port_select && full_cascade_in;
  // read qualified by read clock enable and read enable
  // cascade input is the second read select
  assign rd_req = fifo_mode && read_clock_enable && read_enable_in
                  && read_port_select && empty_cascade_in;
  // full and empty refuse the request
  assign wr_accept = wr_req && !full_flag_reg && buf_in_ready;
  assign rd_accept = rd_req && !empty_flag_reg && buf_out_valid && !rd_restart;
  assign rd_restart = fifo_mode && read_pointer_reset;
  assign fifo_write_ready = !full_flag_reg && buf_in_ready;

  ebm_fifo #(
    .WIDTH(`EBM_DATA_W),
    .DEPTH(`EBM_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rst(rst),
    .rd_ptr_reset(rd_restart),
    .in_valid(wr_accept),
    .in_ready(buf_in_ready),
    .in_data(data_in_bus),
    .out_valid(buf_out_valid),
    .out_ready(rd_accept),
    .out_data(buf_out_data),
    .level(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // flags
  logic [`EBM_ADDR_W-1:0] full_thr;
  logic [`EBM_ADDR_W-1:0] af_thr;
  logic [`EBM_ADDR_W-1:0] ae_thr;
  logic full_next;
  logic almost_full_next;
  logic empty_next;
  logic almost_empty_next;
  logic [`EBM_DATA_W-1:0] fifo_data_out_reg;

  assign full_thr = ebm_clamp(full_threshold, `EBM_THR_MIN, `EBM_THR_MAX);
  assign af_thr = ebm_clamp(almost_full_threshold, `EBM_THR_MIN, full_thr - `EBM_THR_MIN);
  assign ae_thr = ebm_clamp(almost_empty_threshold, `EBM_THR_MIN, full_thr - `EBM_THR_MIN);

  // four flags from the fill level
  assign full_next = (fifo_level >= {1'b0, full_thr});
  assign almost_full_next = (fifo_level >= {1'b0, af_thr});
  assign empty_next = (fifo_level == '0);
  assign almost_empty_next = (fifo_level <= {1'b0, ae_thr});

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      full_flag_reg <= 1'b0;
      almost_full_flag_reg <= 1'b0;
    end else begin
      full_flag_reg <= full_next;
      almost_full_flag_reg <= almost_full_next;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      empty_flag_reg <= 1'b1;
      almost_empty_flag_reg <= 1'b1;
    end else begin
      empty_flag_reg <= empty_next;
      almost_empty_flag_reg <= almost_empty_next;
    end
  end

  // output holds when a read is refused
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fifo_data_out_reg <= '0;
    end else if (rd_accept) begin
      fifo_data_out_reg <= buf_out_data;
    end
  end

  assign full_flag = full_flag_reg;
  assign almost_full_flag = almost_full_flag_reg;
  assign empty_flag = empty_flag_reg;
  assign almost_empty_flag = almost_empty_flag_reg;
  assign fifo_data_out = fifo_data_out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking ebm_cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  normal_hold_a: assert property (
    ram_write && ram_out_load && wmode == ebm_pkg::EBM_NORMAL |=> $stable(ram_data_out)
  ) else $error("normal write changed the ram output");

  normal_read_a: assert property (
    ram_read && output_clk_enable |=> ram_data_out == $past(ram_rd_word)
  ) else $error("read cycle did not show the stored word");

  write_thru_a: assert property (
    ram_write && ram_out_load && wmode == ebm_pkg::EBM_WRITE_THRU
    |=> ram_data_out == $past(data_in_bus)
  ) else $error("write-through word missing on output");

  read_before_a: assert property (
    ram_write && ram_out_load && wmode == ebm_pkg::EBM_READ_BEFORE
    |=> ram_data_out == $past(ram_rd_word)
  ) else $error("old word missing on read-before-write");

  full_flag_a: assert property (
    fifo_level >= {1'b0, full_thr} ##1 $stable(full_threshold) |-> full_flag
  ) else $error("full flag late");

  empty_flag_a: assert property (
    fifo_level == '0 |=> empty_flag && almost_empty_flag
  ) else $error("empty flags not set at zero level");

  thr_range_a: assert property (
    full_thr >= `EBM_THR_MIN && af_thr >= `EBM_THR_MIN
    && (af_thr < full_thr || full_thr == `EBM_THR_MIN)
  ) else $error("threshold out of range");

  no_overflow_a: assert property (
    wr_req && full_flag && !rd_accept && !rd_restart |=> fifo_level == $past(fifo_level)
  ) else $error("write taken while full");

  no_underflow_a: assert property (
    rd_req && empty_flag |=> $stable(fifo_data_out)
  ) else $error("read taken while empty");

  cascade_wr_a: assert property (
    !full_cascade_in && !rd_accept && !rd_restart |=> fifo_level <= $past(fifo_level)
  ) else $error("write taken without cascade select");

  reset_flags_a: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |=> empty_flag && !full_flag && fifo_level == '0
  ) else $error("reset left flags or level set");

  ////////////////////////////////////////////////////////////////////////////
  // port qualification and pointer checks
  write_select_a: assert property (
    !write_port_select && !rd_accept && !rd_restart |=> fifo_level <= $past(fifo_level)
  ) else $error("write taken without write select");

  cascade_rd_a: assert property (
    !empty_cascade_in |=> $stable(fifo_data_out)
  ) else $error("read taken without cascade select");

  restart_hold_a: assert property (
    rd_restart |=> $stable(fifo_data_out)
  ) else $error("read taken in a restart cycle");

  write_taken_a: assert property (
    wr_req && fifo_write_ready && !rd_accept && !rd_restart
    |=> fifo_level == $past(fifo_level) + 5'h01
  ) else $error("qualified write not stored");

  read_taken_a: assert property (
    rd_accept |=> fifo_data_out == $past(buf_out_data)
  ) else $error("accepted read did not load the head word");

  level_step_a: assert property (
    !rd_restart |=> fifo_level <= $past(fifo_level) + 5'h01
  ) else $error("level rose by more than one word");

  ram_quiet_a: assert property (
    !fifo_mode |=> fifo_level == $past(fifo_level) && $stable(fifo_data_out)
  ) else $error("fifo moved in ram mode");

  fifo_quiet_a: assert property (
    fifo_mode |=> $stable(ram_data_out)
  ) else $error("ram output moved in fifo mode");

  ////////////////////////////////////////////////////////////////////////////
  // flag checks; a threshold change excuses the cycle after it
  almost_full_a: assert property (
    fifo_level >= {1'b0, af_thr}
    ##1 ($stable(almost_full_threshold) && $stable(full_threshold)) |-> almost_full_flag
  ) else $error("almost full flag late");

  empty_clear_a: assert property (
    fifo_level != '0 |=> !empty_flag
  ) else $error("empty flag set with words stored");

  almost_empty_a: assert property (
    fifo_level > {1'b0, ae_thr}
    ##1 ($stable(almost_empty_threshold) && $stable(full_threshold))
    |-> !almost_empty_flag
  ) else $error("almost empty flag stuck");

  ae_range_a: assert property (
    ae_thr >= `EBM_THR_MIN
    && (ae_thr < full_thr || full_thr == `EBM_THR_MIN)
  ) else $error("almost empty threshold out of range");

  fill_full_c: cover property (wr_accept ##2 full_flag);
  drain_empty_c: cover property (rd_accept ##2 empty_flag ##1 rd_req);
  thru_c: cover property (ram_write && ram_out_load && wmode == ebm_pkg::EBM_WRITE_THRU);
  rbw_c: cover property (ram_write && ram_out_load && wmode == ebm_pkg::EBM_READ_BEFORE);
  restart_c: cover property (!empty_flag && rd_restart);

endmodule : ebm_top
`default_nettype wire

// file: ebm_map.svh
// constants for the block memory with fifo mode
`ifndef EBM_MAP_SVH
`define EBM_MAP_SVH
`define EBM_DATA_W 8
`define EBM_ADDR_W 4
`define EBM_DEPTH 16
`define EBM_LEVEL_W 5
`define EBM_THR_MIN 4'h1
`define EBM_THR_MAX 4'hF
`define EBM_MODE_W 2
`endif

// file: ebm_pkg.sv
// types for the block memory with fifo mode
package ebm_pkg;
  typedef enum logic [1:0] {
    EBM_NORMAL,
    EBM_WRITE_THRU,
    EBM_READ_BEFORE
  } ebm_wmode_type;
endpackage : ebm_pkg

// file: ebm_fifo.sv
// flip-flop fifo with pointer storage and a read-pointer-only restart
`timescale 1ns/1ps
`default_nettype none
module ebm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic rd_ptr_reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] raw_level;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // a read restart after the write pointer wrapped saturates at a full buffer
  assign raw_level = wr_ptr_reg - rd_ptr_reg;
  assign level = (raw_level > DEPTH_W) ? DEPTH_W : raw_level;
  assign in_ready = (level < DEPTH_W);
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store_reg[rd_ptr_reg[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
    end else if (push) begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(1);
    end
  end

  // restart wins over a read in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_ptr_reg <= '0;
    end else if (rd_ptr_reset) begin
      rd_ptr_reg <= '0;
    end else if (pop) begin
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(1);
    end
  end

  // storage is not cleared by reset; pointers decide what is valid
  always_ff @(posedge core_clk) begin
    if (push) begin
      store_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule : ebm_fifo
`default_nettype wire

// file: ebm_user_model.sv
// user-side model of the fifo write and read ports
`timescale 1ns/1ps
`default_nettype none
module ebm_user_model (
  input wire logic push,
  input wire logic pop,
  input wire logic over_req,
  input wire logic [3:0] wr_qual,
  input wire logic [3:0] rd_qual,
  input wire logic full_flag,
  input wire logic empty_flag,
  output logic write_clock_enable,
  output logic write_enable,
  output logic write_port_select,
  output logic full_cascade_in,
  output logic read_clock_enable,
  output logic read_enable_in,
  output logic read_port_select,
  output logic empty_cascade_in
);
  logic wr_go;
  logic rd_go;
  // no write while full
  // over_req lets a scenario break this on purpose
  assign wr_go = push && (over_req || !full_flag);
  assign rd_go = pop && (over_req || !empty_flag);
  ////////////////////////////////////////////////////////////
  // write and read qualifiers
  assign {write_clock_enable, write_enable, write_port_select, full_cascade_in} =
    wr_go ? wr_qual : 4'h0;
  assign {read_clock_enable, read_enable_in, read_port_select, empty_cascade_in} =
    rd_go ? rd_qual : 4'h0;
endmodule : ebm_user_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the block memory with fifo mode
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0] FT = 4'h6;
  localparam logic [3:0] AFT = 4'h4;
  localparam logic [3:0] AET = 4'h2;
  logic [3:0] ft = FT;
  logic [3:0] aft = AFT;
  logic [3:0] aet = AET;
  logic [3:0] exp_ft = FT;
  logic [3:0] exp_af = AFT;
  logic [3:0] exp_ae = AET;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic fifo_mode = 1'b0;
  logic [1:0] write_mode = 2'h0;
  logic ram_en = 1'b0;
  logic ram_we = 1'b0;
  logic [3:0] ram_addr = 4'h0;
  logic [7:0] data_in_bus = 8'h00;
  logic read_pointer_reset = 1'b0;
  logic push = 1'b0;
  logic pop = 1'b0;
  logic over_req = 1'b0;
  logic [3:0] wr_qual = 4'hF;
  logic [3:0] rd_qual = 4'hF;
  logic [7:0] ram_data_out;
  logic [7:0] fifo_data_out;
  logic fifo_write_ready;
  logic full_flag;
  logic almost_full_flag;
  logic empty_flag;
  logic almost_empty_flag;
  logic write_clock_enable;
  logic write_enable;
  logic write_port_select;
  logic full_cascade_in;
  logic read_clock_enable;
  logic read_enable_in;
  logic read_port_select;
  logic empty_cascade_in;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] ro;
  logic [7:0] exp;
  always #25 core_clk = ~core_clk;
  ebm_top ebm_top_i (
    .core_clk, .rst, .fifo_mode, .write_mode,
    .ram_clk_enable(ram_en), .ram_select(ram_en), .ram_write_enable(ram_we),
    .output_clk_enable(1'b1), .ram_addr, .data_in_bus, .ram_data_out,
    .write_clock_enable, .write_enable, .write_port_select, .full_cascade_in,
    .read_clock_enable, .read_enable_in, .read_port_select, .empty_cascade_in,
    .read_pointer_reset, .full_threshold(ft), .almost_full_threshold(aft),
    .almost_empty_threshold(aet), .fifo_data_out, .fifo_write_ready,
    .full_flag, .almost_full_flag, .empty_flag, .almost_empty_flag
  );
  ebm_user_model ebm_user_model_i (
    .push, .pop, .over_req, .wr_qual, .rd_qual, .full_flag, .empty_flag,
    .write_clock_enable, .write_enable, .write_port_select, .full_cascade_in,
    .read_clock_enable, .read_enable_in, .read_port_select, .empty_cascade_in
  );
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  // flags lag the level by one edge, so wait one before looking
  task automatic flags(input int lvl);
    @(posedge core_clk);
    #1;
    check({3'h0, fifo_write_ready, full_flag, almost_full_flag, empty_flag,
      almost_empty_flag}, {3'h0, lvl < exp_ft, lvl >= exp_ft, lvl >= exp_af, lvl == 0,
      lvl <= exp_ae});
  endtask : flags
  task automatic ram_op(input logic [1:0] m, input logic w, input logic [3:0] a,
    input logic [7:0] d);
    @(posedge core_clk);
    write_mode <= m;
    ram_en <= 1'b1;
    ram_we <= w;
    ram_addr <= a;
    data_in_bus <= d;
    @(posedge core_clk);
    ram_en <= 1'b0;
    #1;
  endtask : ram_op
  task automatic fifo_op(input logic p, input logic q, input logic [7:0] d);
    @(posedge core_clk);
    push <= p;
    pop <= q;
    data_in_bus <= d;
    @(posedge core_clk);
    push <= 1'b0;
    pop <= 1'b0;
    #1;
  endtask : fifo_op
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check(ram_data_out, 8'h00);
    check(fifo_data_out, 8'h00);
    flags(0);
    for (int i = 0; i < 3; i++) ram_op(2'h0, 1'b1, i[3:0], 8'h10 + i[7:0]);
    ram_op(2'h0, 1'b0, 4'h0, 8'h00);
    ro = 8'h10;
    check(ram_data_out, ro);
    for (int m = 0; m < 3; m++) begin
      ram_op(m[1:0], 1'b1, m[3:0], 8'hA0 + m[7:0]);
      exp = (m == 0) ? ro : (m == 1) ? 8'hA0 + m[7:0] : 8'h10 + m[7:0];
      check(ram_data_out, exp);
      ram_op(m[1:0], 1'b0, m[3:0], 8'h00);
      ro = 8'hA0 + m[7:0];
      check(ram_data_out, ro);
    end
    // the spare mode code behaves as a normal write
    ram_op(2'h3, 1'b1, 4'h0, 8'hB3);
    check(ram_data_out, ro);
    ram_op(2'h3, 1'b0, 4'h0, 8'h00);
    check(ram_data_out, 8'hB3);
    @(posedge core_clk);
    fifo_mode <= 1'b1;
    for (n = 0; n < FT; n++) begin
      fifo_op(1'b1, 1'b0, 8'h30 + n[7:0]);
      flags(n + 1);
    end
    over_req <= 1'b1;
    fifo_op(1'b1, 1'b0, 8'hEE);
    flags(FT);
    for (n = 0; n < FT; n++) begin
      fifo_op(1'b0, 1'b1, 8'h00);
      check(fifo_data_out, 8'h30 + n[7:0]);
      flags(FT - 1 - n);
    end
    fifo_op(1'b0, 1'b1, 8'h00);
    check(fifo_data_out, 8'h35);
    flags(0);
    over_req <= 1'b0;
    // dropping any one qualifier must block the request
    for (int k = 0; k < 4; k++) begin
      wr_qual <= 4'hF ^ (4'h1 << k);
      fifo_op(1'b1, 1'b0, 8'h99);
      flags(0);
    end
    wr_qual <= 4'hF;
    fifo_op(1'b1, 1'b0, 8'h55);
    flags(1);
    for (int k = 0; k < 4; k++) begin
      rd_qual <= 4'hF ^ (4'h1 << k);
      fifo_op(1'b0, 1'b1, 8'h00);
      check(fifo_data_out, 8'h35);
    end
    rd_qual <= 4'hF;
    // restart reads: write pointer sits at 7, level follows it
    @(posedge core_clk);
    read_pointer_reset <= 1'b1;
    @(posedge core_clk);
    read_pointer_reset <= 1'b0;
    #1;
    flags(7);
    fifo_op(1'b0, 1'b1, 8'h00);
    check(fifo_data_out, 8'h30);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check(fifo_data_out, 8'h00);
    flags(0);
    @(posedge core_clk);
    push <= 1'b1;
    data_in_bus <= 8'h81;
    @(posedge core_clk);
    data_in_bus <= 8'h82;
    @(posedge core_clk);
    push <= 1'b0;
    flags(2);
    fifo_op(1'b0, 1'b1, 8'h00);
    check(fifo_data_out, 8'h81);
    fifo_op(1'b0, 1'b1, 8'h00);
    check(fifo_data_out, 8'h82);
    flags(0);
    // out-of-range thresholds clamp to the nearest legal value
    @(posedge core_clk);
    ft <= 4'h0;
    aft <= 4'hF;
    aet <= 4'h0;
    exp_ft = 4'h1;
    exp_af = 4'h1;
    exp_ae = 4'h1;
    flags(0);
    fifo_op(1'b1, 1'b0, 8'h77);
    flags(1);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
